/* core/daa_ring_cal_monitor_regs.sv */
// register bank for calibration, ring mode, dropout and monitor levels
// assumes a single-cycle strobed register port and async detector pins
// Notes on behaviour
// - calibration disable bit suppresses automatic calibration
// - no validation: half or full wave detect
// - validation: envelope, or threshold one-shot timeout
// - dropout flag reads one while dropout detected
// - receive monitor level scales linearly, 0x40 unity
// - receive level zero mutes receive monitor
// - transmit monitor level scales the same way
// - transmit level zero mutes transmit monitor
`default_nettype none
module daa_ring_cal_monitor_regs #(
    parameter int ONESHOT_CYCLES = ring_mon_pkg::ONESHOT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ring_mon_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ring_mon_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ring_mon_pkg::DATA_W-1:0] reg_rdata,
    // detector pins, asynchronous
    input wire logic ring_half_wave_in,
    input wire logic ring_full_wave_in,
    input wire logic ring_envelope_in,
    input wire logic ring_threshold_in,
    input wire logic dropout_in,
    // same-clock configuration from the validation logic
    input wire logic ring_validation_enable,
    // calibration control
    output logic adc_auto_cal_en,
    // monitor samples
    input wire logic monitor_sample_valid,
    input wire logic [ring_mon_pkg::SAMPLE_W-1:0] monitor_rx_sample,
    input wire logic [ring_mon_pkg::SAMPLE_W-1:0] monitor_tx_sample,
    output logic monitor_out_valid,
    output logic [ring_mon_pkg::SAMPLE_W-1:0] call_progress_monitor_out,
    // status
    output logic ring_indication,
    output logic irq
);
    function automatic logic hit(
        input logic [ring_mon_pkg::ADDR_W-1:0] a,
        input logic [ring_mon_pkg::ADDR_W-1:0] off
    );
        hit = (a == off);
    endfunction

    // pin synchronisers: three stages, filtered on stage two/three agree
    logic [ring_mon_pkg::PIN_W-1:0] pins;
    logic [ring_mon_pkg::PIN_W-1:0] s1_q;
    logic [ring_mon_pkg::PIN_W-1:0] s2_q;
    logic [ring_mon_pkg::PIN_W-1:0] s3_q;
    logic [ring_mon_pkg::PIN_W-1:0] flt_q;
    logic [ring_mon_pkg::PIN_W-1:0] flt_d;

    assign pins = {dropout_in, ring_threshold_in, ring_envelope_in,
                   ring_full_wave_in, ring_half_wave_in};

    genvar gi;
    generate
        for (gi = 0; gi < ring_mon_pkg::PIN_W; gi++)
        begin : g_pin
            always_comb
            begin
                flt_d[gi] = flt_q[gi];
                if (s2_q[gi] == s3_q[gi])
                    flt_d[gi] = s3_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    // control registers
    logic cal_dis_q;
    logic cal_dis_d;
    logic full_wave_q;
    logic full_wave_d;
    logic [ring_mon_pkg::DATA_W-1:0] rx_att_q;
    logic [ring_mon_pkg::DATA_W-1:0] rx_att_d;
    logic [ring_mon_pkg::DATA_W-1:0] tx_att_q;
    logic [ring_mon_pkg::DATA_W-1:0] tx_att_d;
    logic [ring_mon_pkg::EV_W-1:0] mask_q;
    logic [ring_mon_pkg::EV_W-1:0] mask_d;
    logic [ring_mon_pkg::EV_W-1:0] stat_q;
    logic [ring_mon_pkg::EV_W-1:0] stat_d;
    logic [ring_mon_pkg::EV_W-1:0] events;
    logic [ring_mon_pkg::EV_W-1:0] w1c;
    logic drop_prev_q;
    logic drop_prev_d;
    logic ring_prev_q;
    logic ring_prev_d;
    logic ring_ind;

    // reserved bits are dropped on write, so reads give zero
    always_comb
    begin
        cal_dis_d = cal_dis_q;
        full_wave_d = full_wave_q;
        rx_att_d = rx_att_q;
        tx_att_d = tx_att_q;
        mask_d = mask_q;
        w1c = '0;
        if (reg_wr)
        begin
            if (hit(reg_addr, ring_mon_pkg::OFF_CAL))
                cal_dis_d = reg_wdata[ring_mon_pkg::CAL_DIS_BIT];
            if (hit(reg_addr, ring_mon_pkg::OFF_RING_MODE))
                full_wave_d = reg_wdata[ring_mon_pkg::FULL_WAVE_BIT];
            if (hit(reg_addr, ring_mon_pkg::OFF_RX_ATTEN))
                rx_att_d = reg_wdata;
            if (hit(reg_addr, ring_mon_pkg::OFF_TX_ATTEN))
                tx_att_d = reg_wdata;
            if (hit(reg_addr, ring_mon_pkg::OFF_IRQ_MASK))
                mask_d = reg_wdata[ring_mon_pkg::EV_W-1:0];
            if (hit(reg_addr, ring_mon_pkg::OFF_IRQ_STATUS))
                w1c = reg_wdata[ring_mon_pkg::EV_W-1:0];
        end
        drop_prev_d = flt_q[ring_mon_pkg::PIN_DROP];
        ring_prev_d = ring_ind;
        events[ring_mon_pkg::EV_DROPOUT] =
            flt_q[ring_mon_pkg::PIN_DROP] & ~drop_prev_q;
        events[ring_mon_pkg::EV_RING] = ring_ind & ~ring_prev_q;
        // a new event wins over a clear in the same cycle
        stat_d = (stat_q & ~w1c) | events;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cal_dis_q <= ring_mon_pkg::CTRL_RST;
            full_wave_q <= ring_mon_pkg::CTRL_RST;
            rx_att_q <= ring_mon_pkg::ATTEN_RST;
            tx_att_q <= ring_mon_pkg::ATTEN_RST;
            mask_q <= ring_mon_pkg::EV_RST;
            stat_q <= ring_mon_pkg::EV_RST;
            drop_prev_q <= 1'b0;
            ring_prev_q <= 1'b0;
        end
        else
        begin
            cal_dis_q <= cal_dis_d;
            full_wave_q <= full_wave_d;
            rx_att_q <= rx_att_d;
            tx_att_q <= tx_att_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            drop_prev_q <= drop_prev_d;
            ring_prev_q <= ring_prev_d;
        end
    end

    assign adc_auto_cal_en = ~cal_dis_q;
    assign irq = |(stat_q & mask_q);
    assign ring_indication = ring_ind;

    // read port: data only in the cycle after the strobe, else zero
    logic [ring_mon_pkg::DATA_W-1:0] rdata_q;
    logic [ring_mon_pkg::DATA_W-1:0] rdata_d;

    always_comb
    begin
        rdata_d = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                ring_mon_pkg::OFF_CAL:
                    rdata_d[ring_mon_pkg::CAL_DIS_BIT] = cal_dis_q;
                ring_mon_pkg::OFF_RING_MODE:
                    rdata_d[ring_mon_pkg::FULL_WAVE_BIT] = full_wave_q;
                ring_mon_pkg::OFF_DROPOUT:
                    rdata_d[ring_mon_pkg::DROPOUT_BIT] =
                        flt_q[ring_mon_pkg::PIN_DROP];
                ring_mon_pkg::OFF_RX_ATTEN:
                    rdata_d = rx_att_q;
                ring_mon_pkg::OFF_TX_ATTEN:
                    rdata_d = tx_att_q;
                ring_mon_pkg::OFF_IRQ_STATUS:
                    rdata_d[ring_mon_pkg::EV_W-1:0] = stat_q;
                ring_mon_pkg::OFF_IRQ_MASK:
                    rdata_d[ring_mon_pkg::EV_W-1:0] = mask_q;
                default:
                    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    // ring source selection
    ring_indicator #(
        .ONESHOT_CYCLES(ONESHOT_CYCLES)
    ) u_ring (
        .clk(clk),
        .sys_rst(sys_rst),
        .validation_en(ring_validation_enable),
        .full_wave_sel(full_wave_q),
        .half_wave_det(flt_q[ring_mon_pkg::PIN_HALF]),
        .full_wave_det(flt_q[ring_mon_pkg::PIN_FULL]),
        .ring_envelope(flt_q[ring_mon_pkg::PIN_ENV]),
        .ring_threshold(flt_q[ring_mon_pkg::PIN_THR]),
        .ring_indication(ring_ind),
        .oneshot_active()
    );

    // monitor paths
    logic [ring_mon_pkg::SAMPLE_W-1:0] rx_scaled;
    logic [ring_mon_pkg::SAMPLE_W-1:0] tx_scaled;
    logic rx_vld;

    monitor_scaler u_rx (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample_valid(monitor_sample_valid),
        .sample(monitor_rx_sample),
        .level_code(rx_att_q),
        .scaled_valid(rx_vld),
        .scaled(rx_scaled)
    );

    monitor_scaler u_tx (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample_valid(monitor_sample_valid),
        .sample(monitor_tx_sample),
        .level_code(tx_att_q),
        .scaled_valid(),
        .scaled(tx_scaled)
    );

    // both paths share one output, so the mix saturates
    logic [ring_mon_pkg::SAMPLE_W-1:0] mix_q;
    logic [ring_mon_pkg::SAMPLE_W-1:0] mix_d;
    logic mix_vld_q;
    logic mix_vld_d;
    logic signed [ring_mon_pkg::WIDE_W-1:0] sum;

    always_comb
    begin
        sum = ring_mon_pkg::WIDE_W'(signed'(rx_scaled))
            + ring_mon_pkg::WIDE_W'(signed'(tx_scaled));
        mix_d = mix_q;
        mix_vld_d = rx_vld;
        if (rx_vld)
            mix_d = ring_mon_pkg::sat_s(sum);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mix_q <= '0;
            mix_vld_q <= 1'b0;
        end
        else
        begin
            mix_q <= mix_d;
            mix_vld_q <= mix_vld_d;
        end
    end

    assign call_progress_monitor_out = mix_q;
    assign monitor_out_valid = mix_vld_q;

    cal_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == ring_mon_pkg::OFF_CAL
        |=> adc_auto_cal_en == !$past(reg_wdata[ring_mon_pkg::CAL_DIS_BIT]))
        else $error("calibration enable did not follow write");
    dropout_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == ring_mon_pkg::OFF_DROPOUT
        |=> reg_rdata == {6'h00, $past(flt_q[ring_mon_pkg::PIN_DROP]), 1'b0})
        else $error("dropout flag read wrong");
    dropout_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
        s2_q[ring_mon_pkg::PIN_DROP] && s3_q[ring_mon_pkg::PIN_DROP]
        |=> flt_q[ring_mon_pkg::PIN_DROP])
        else $error("stable dropout not taken");
    rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside read slot");
    irq_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
        events[ring_mon_pkg::EV_RING] |=> stat_q[ring_mon_pkg::EV_RING])
        else $error("ring event lost");
    irq_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_wr && reg_addr == ring_mon_pkg::OFF_IRQ_STATUS
        && reg_wdata[ring_mon_pkg::EV_DROPOUT]
        && !events[ring_mon_pkg::EV_DROPOUT]
        |=> !stat_q[ring_mon_pkg::EV_DROPOUT])
        else $error("dropout status not cleared");
    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        stat_q == '0 |-> !irq)
        else $error("interrupt without status");
    rx_mute_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        rx_att_q == ring_mon_pkg::ATTEN_MUTE
        && tx_att_q == ring_mon_pkg::ATTEN_MUTE && monitor_sample_valid
        ##1 rx_att_q == ring_mon_pkg::ATTEN_MUTE
        |=> call_progress_monitor_out == '0)
        else $error("muted monitor not silent");
endmodule // daa_ring_cal_monitor_regs
`default_nettype wire

/* shared/ring_mon_pkg.sv */
// constants, register map and helpers shared by the ring/monitor block
// assumes a single 200 MHz clock domain and an 8-bit register port
`default_nettype none
package ring_mon_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int WIDE_W = 20;

    localparam logic [7:0] OFF_RSVD_A = 8'h10;
    localparam logic [7:0] OFF_CAL = 8'h11;
    localparam logic [7:0] OFF_RING_MODE = 8'h12;
    localparam logic [7:0] OFF_DROPOUT = 8'h13;
    localparam logic [7:0] OFF_RX_ATTEN = 8'h14;
    localparam logic [7:0] OFF_TX_ATTEN = 8'h15;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h31;

    localparam int CAL_DIS_BIT = 5;
    localparam int FULL_WAVE_BIT = 1;
    localparam int DROPOUT_BIT = 1;

    localparam int EV_W = 2;
    localparam int EV_DROPOUT = 0;
    localparam int EV_RING = 1;

    localparam int PIN_W = 5;
    localparam int PIN_HALF = 0;
    localparam int PIN_FULL = 1;
    localparam int PIN_ENV = 2;
    localparam int PIN_THR = 3;
    localparam int PIN_DROP = 4;

    localparam logic CTRL_RST = 1'b0;
    localparam logic [7:0] ATTEN_RST = 8'h00;
    localparam logic [7:0] ATTEN_MUTE = 8'h00;
    localparam logic [7:0] ATTEN_UNITY = 8'h40;
    localparam int ATTEN_SHIFT = 6;
    localparam logic [EV_W-1:0] EV_RST = 2'h0;

    localparam int CLK_MHZ = 200;
    localparam int ONESHOT_MS = 5000;
    localparam int ONESHOT_CYCLES = ONESHOT_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 30;

    function automatic logic [SAMPLE_W-1:0] sat_s(
        input logic signed [WIDE_W-1:0] v
    );
        logic signed [WIDE_W-1:0] hi;
        logic signed [WIDE_W-1:0] lo;
        hi = WIDE_W'(signed'(16'sh7fff));
        lo = WIDE_W'(signed'(16'sh8000));
        if (v > hi)
            sat_s = 16'h7fff;
        else if (v < lo)
            sat_s = 16'h8000;
        else
            sat_s = v[SAMPLE_W-1:0];
    endfunction
endpackage
`default_nettype wire

/* core/monitor_scaler.sv */
// linear level scaling of one monitor path, code 8'h40 is unity gain
// assumes samples arrive as signed words with a one-cycle valid strobe
`default_nettype none
module monitor_scaler (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sample in
    input wire logic sample_valid,
    input wire logic [ring_mon_pkg::SAMPLE_W-1:0] sample,
    input wire logic [ring_mon_pkg::DATA_W-1:0] level_code,
    // scaled sample out
    output logic scaled_valid,
    output logic [ring_mon_pkg::SAMPLE_W-1:0] scaled
);
    logic [ring_mon_pkg::SAMPLE_W-1:0] out_q;
    logic [ring_mon_pkg::SAMPLE_W-1:0] out_d;
    logic vld_q;
    logic vld_d;
    logic signed [24:0] prod;
    logic signed [ring_mon_pkg::WIDE_W-1:0] shifted;

    always_comb
    begin
        prod = signed'(sample) * signed'({1'b0, level_code});
        shifted = ring_mon_pkg::WIDE_W'(prod >>> ring_mon_pkg::ATTEN_SHIFT);
        vld_d = sample_valid;
        out_d = out_q;
        if (sample_valid)
        begin
            // explicit mute, not left to the multiply
            if (level_code == ring_mon_pkg::ATTEN_MUTE)
                out_d = '0;
            else
                out_d = ring_mon_pkg::sat_s(shifted);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_q <= '0;
            vld_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign scaled = out_q;
    assign scaled_valid = vld_q;

    path_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_valid && level_code == ring_mon_pkg::ATTEN_MUTE
        |=> scaled == '0)
        else $error("muted path gave a nonzero sample");
    unity_gain_a: assert property (@(posedge clk) disable iff (sys_rst)
        sample_valid && level_code == ring_mon_pkg::ATTEN_UNITY
        |=> scaled == $past(sample))
        else $error("unity code changed the sample");
endmodule // monitor_scaler
`default_nettype wire

/* core/ring_indicator.sv */
// ring indication source selection and the threshold one-shot
// assumes detector levels are already synchronised to clk
`default_nettype none
module ring_indicator #(
    parameter int ONESHOT_CYCLES = ring_mon_pkg::ONESHOT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // mode
    input wire logic validation_en,
    input wire logic full_wave_sel,
    // detector levels
    input wire logic half_wave_det,
    input wire logic full_wave_det,
    input wire logic ring_envelope,
    input wire logic ring_threshold,
    // result
    output logic ring_indication,
    output logic oneshot_active
);
    localparam logic [ring_mon_pkg::CNT_W-1:0] LAST =
        ring_mon_pkg::CNT_W'(ONESHOT_CYCLES - 1);

    logic thr_prev_q;
    logic thr_prev_d;
    logic shot_q;
    logic shot_d;
    logic ind_q;
    logic ind_d;
    logic [ring_mon_pkg::CNT_W-1:0] cnt_q;
    logic [ring_mon_pkg::CNT_W-1:0] cnt_d;
    logic thr_rise;

    always_comb
    begin
        thr_rise = ring_threshold & ~thr_prev_q;
        thr_prev_d = ring_threshold;
        shot_d = shot_q;
        cnt_d = cnt_q;
        // not retriggered: a crossing while running is ignored
        if (shot_q)
        begin
            if (cnt_q == LAST)
            begin
                shot_d = 1'b0;
                cnt_d = '0;
            end
            else
                cnt_d = cnt_q + 1'b1;
        end
        else if (thr_rise)
        begin
            shot_d = 1'b1;
            cnt_d = '0;
        end
        case ({validation_en, full_wave_sel})
            2'h0: ind_d = half_wave_det;
            2'h1: ind_d = full_wave_det;
            2'h2: ind_d = ring_envelope;
            2'h3: ind_d = shot_q;
            default: ind_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            thr_prev_q <= 1'b0;
            shot_q <= 1'b0;
            ind_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            thr_prev_q <= thr_prev_d;
            shot_q <= shot_d;
            ind_q <= ind_d;
            cnt_q <= cnt_d;
        end
    end

    assign ring_indication = ind_q;
    assign oneshot_active = shot_q;

    half_wave_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
        !validation_en && !full_wave_sel
        |=> ring_indication == $past(half_wave_det))
        else $error("half-wave mode not followed");
    full_wave_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
        !validation_en && full_wave_sel
        |=> ring_indication == $past(full_wave_det))
        else $error("full-wave mode not followed");
    envelope_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
        validation_en && !full_wave_sel
        |=> ring_indication == $past(ring_envelope))
        else $error("envelope mode not followed");
    oneshot_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(shot_q) |-> $past(cnt_q) == LAST)
        else $error("one-shot ended at the wrong count");
    oneshot_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        !shot_q && ring_threshold && !thr_prev_q
        |=> shot_q && cnt_q == '0)
        else $error("threshold crossing did not start one-shot");
endmodule // ring_indicator
`default_nettype wire

/* test/host_model.sv */
// host software stand-in driving the strobed register port
// assumes read data stand in the cycle after the read strobe only
`default_nettype none
module host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [ring_mon_pkg::ADDR_W-1:0] reg_addr,
    output logic [ring_mon_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [ring_mon_pkg::DATA_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // callers pass only defined bits, reserved ones stay zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released lines show junk, not a held value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the ring, calibration and monitor registers
// assumes a shortened one-shot so the timeout case stays brief
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OS = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd;
    logic [3:0] det = 4'h0;
    logic dropout_in = 1'b0;
    logic ring_validation_enable = 1'b0;
    logic adc_auto_cal_en, monitor_out_valid, ring_indication, irq;
    logic monitor_sample_valid = 1'b0;
    logic [15:0] monitor_rx_sample = 16'h0000;
    logic [15:0] monitor_tx_sample = 16'h0000;
    logic [15:0] call_progress_monitor_out;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    host_model host_model_i (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    daa_ring_cal_monitor_regs #(.ONESHOT_CYCLES(OS))
        daa_ring_cal_monitor_regs_i (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ring_half_wave_in(det[0]), .ring_full_wave_in(det[1]),
        .ring_envelope_in(det[2]), .ring_threshold_in(det[3]),
        .dropout_in(dropout_in),
        .ring_validation_enable(ring_validation_enable),
        .adc_auto_cal_en(adc_auto_cal_en),
        .monitor_sample_valid(monitor_sample_valid),
        .monitor_rx_sample(monitor_rx_sample),
        .monitor_tx_sample(monitor_tx_sample),
        .monitor_out_valid(monitor_out_valid),
        .call_progress_monitor_out(call_progress_monitor_out),
        .ring_indication(ring_indication), .irq(irq));

    task automatic complete_run;
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model_i.rd(a, d);
        check($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, d});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // floor division by 64, as an arithmetic shift does
    function automatic int exp_scale(input int s, input int c);
        return (s * c) >>> 6;
    endfunction

    task automatic t_reset;
        logic [7:0] a [6] = '{ring_mon_pkg::OFF_RSVD_A,
            ring_mon_pkg::OFF_CAL, ring_mon_pkg::OFF_RING_MODE,
            ring_mon_pkg::OFF_RX_ATTEN, ring_mon_pkg::OFF_TX_ATTEN, 8'h20};
        foreach (a[i])
            rchk(a[i], 8'h00);
        check("cal_en_rst", 16'h1, {15'h0, adc_auto_cal_en});
        check("irq_rst", 16'h0, {15'h0, irq});
    endtask

    task automatic t_cal;
        host_model_i.wr(ring_mon_pkg::OFF_CAL, 8'h20);
        rchk(ring_mon_pkg::OFF_CAL, 8'h20);
        check("cal_off", 16'h0, {15'h0, adc_auto_cal_en});
        host_model_i.wr(ring_mon_pkg::OFF_CAL, 8'h00);
        wait_cyc(1);
        check("cal_on", 16'h1, {15'h0, adc_auto_cal_en});
    endtask

    // every mode: wrong sources high give 0, the right one gives 1
    task automatic t_ring;
        int m;
        for (m = 0; m < 4; m++)
        begin
            @(posedge clk) ring_validation_enable <= m[1];
            host_model_i.wr(ring_mon_pkg::OFF_RING_MODE, {6'h00, m[0], 1'b0});
            @(posedge clk) det <= 4'hf & ~(4'h1 << m);
            wait_cyc(8);
            check("ring_idle", 16'h0, {15'h0, ring_indication});
            @(posedge clk) det <= 4'hf;
            wait_cyc(8);
            check("ring_on", 16'h1, {15'h0, ring_indication});
            if (m == 3)
            begin
                wait_cyc(OS + 4);
                check("ring_shot_end", 16'h0, {15'h0, ring_indication});
            end
            @(posedge clk) det <= 4'h0;
            wait_cyc(OS + 8);
        end
    endtask

    task automatic t_drop;
        host_model_i.wr(ring_mon_pkg::OFF_IRQ_STATUS, 8'h03);
        rchk(ring_mon_pkg::OFF_DROPOUT, 8'h00);
        host_model_i.wr(ring_mon_pkg::OFF_IRQ_MASK, 8'h01);
        @(posedge clk) dropout_in <= 1'b1;
        wait_cyc(8);
        rchk(ring_mon_pkg::OFF_DROPOUT, 8'h02);
        rchk(ring_mon_pkg::OFF_IRQ_STATUS, 8'h01);
        check("irq_set", 16'h1, {15'h0, irq});
        host_model_i.wr(ring_mon_pkg::OFF_IRQ_MASK, 8'h00);
        wait_cyc(1);
        check("irq_masked", 16'h0, {15'h0, irq});
        host_model_i.wr(ring_mon_pkg::OFF_IRQ_MASK, 8'h01);
        @(posedge clk) dropout_in <= 1'b0;
        wait_cyc(8);
        rchk(ring_mon_pkg::OFF_DROPOUT, 8'h00);
        check("irq_sticky", 16'h1, {15'h0, irq});
        host_model_i.wr(ring_mon_pkg::OFF_IRQ_STATUS, 8'h01);
        wait_cyc(1);
        check("irq_clear", 16'h0, {15'h0, irq});
    endtask

    task automatic mon(input logic [15:0] exp);
        @(posedge clk);
        monitor_sample_valid <= 1'b1;
        monitor_rx_sample <= 16'sd1000;
        monitor_tx_sample <= -16'sd1000;
        @(posedge clk) monitor_sample_valid <= 1'b0;
        wait_cyc(1);
        check("mon_valid", 16'h1, {15'h0, monitor_out_valid});
        check("mon_out", exp, call_progress_monitor_out);
    endtask

    task automatic t_mon;
        logic [7:0] codes [5] = '{8'h7f, 8'h40, 8'h20, 8'h10, 8'h00};
        foreach (codes[i])
        begin
            host_model_i.wr(ring_mon_pkg::OFF_RX_ATTEN, codes[i]);
            host_model_i.wr(ring_mon_pkg::OFF_TX_ATTEN, 8'h00);
            rchk(ring_mon_pkg::OFF_RX_ATTEN, codes[i]);
            mon(16'(exp_scale(1000, int'(codes[i]))));
            host_model_i.wr(ring_mon_pkg::OFF_RX_ATTEN, 8'h00);
            host_model_i.wr(ring_mon_pkg::OFF_TX_ATTEN, codes[i]);
            mon(16'(exp_scale(-1000, int'(codes[i]))));
        end
    endtask

    // whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_cal();
        t_ring();
        t_drop();
        t_mon();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
